// ===== rtl/rtc_tamper_trim_reset.sv
// Purpose: Tamper latch with timestamp, trim code, trim pin and reset pin
// Assumes: Timekeeper counters live outside and feed live_time
// Notes: Register indexes 0..8; read data appear one cycle after rd
`timescale 1ns/10ps
`default_nettype none
module rtc_tamper_trim_reset #(
  parameter int TRIM_HALF_CYCLES = rtc_pkg::TRIM_HALF_CYCLES,
  parameter int FILTER_CYCLES = rtc_pkg::FILTER_CYCLES,
  parameter int HOLD_CYCLES = rtc_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire rtc_pkg::regbus_req_type bus_req,
  output logic [7:0] rd_data,
  // Device pins
  input wire logic tamper_input,
  input wire logic main_supply_valid,
  input wire logic supply_above_trip,
  output logic trim_out,
  output logic sys_reset_o,
  output logic sys_reset_oe,
  // Timekeeper side
  input wire rtc_pkg::time_type live_time,
  output rtc_pkg::time_type time_regs,
  output rtc_pkg::trim_adjust_type trim_adjust,
  output logic freeze_updates,
  output logic core_load
);
  import rtc_pkg::*;

  typedef enum logic [1:0] {
    ARMED = 2'b01,
    LATCHED = 2'b10
  } tamper_state_type;

  tamper_state_type tamper_reg;
  tamper_state_type tamper_next;
  logic tin_meta;
  logic tin_sync;
  logic tin_prev;
  logic vdd_meta;
  logic vdd_sync;
  logic tin_rise;
  logic wr_ctrl;
  logic wr_trim;
  logic tamper_clear;
  logic tamper_accept;
  logic capture;
  logic stamp;
  logic time_wr_any;
  logic trim_mode_reg;
  logic wbit_reg;
  logic rbit_reg;
  logic timestamp_enable_reg;
  logic [5:0] trim_code_reg;
  logic [31:0] trim_cnt_reg;
  time_type time_hold;
  logic trim_seen_reg;
  logic [31:0] trim_run_reg;

  // Tamper pin synchroniser; only the second stage feeds the edge detector
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tin_meta <= 1'b0;
      tin_sync <= 1'b0;
      tin_prev <= 1'b0;
    end else begin
      tin_meta <= tamper_input;
      tin_sync <= tin_meta;
      tin_prev <= tin_sync;
    end
  end

  // Main supply valid level, also from a pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      vdd_meta <= 1'b0;
      vdd_sync <= 1'b0;
    end else begin
      vdd_meta <= main_supply_valid;
      vdd_sync <= vdd_meta;
    end
  end

  // Request decode
  assign tin_rise = tin_sync && !tin_prev;
  assign wr_ctrl = bus_req.wr && (bus_req.addr == ADDR_CTRL);
  assign wr_trim = bus_req.wr && (bus_req.addr == ADDR_TRIM);
  assign time_wr_any = bus_req.wr && (bus_req.addr >= ADDR_TIME0) && (bus_req.addr <= ADDR_TIME_LAST);

  // Writing zero to the flag clears it, but never on a failing supply
  assign tamper_clear = wr_ctrl && !bus_req.wdata[TAMPER_BIT] && vdd_sync;

  // An edge in the clearing cycle counts, so no event is lost
  assign tamper_accept = tin_rise && ((tamper_reg == ARMED) || tamper_clear);

  // Capture only on a 0 to 1 change of the read bit
  assign capture = wr_ctrl && bus_req.wdata[READ_BIT] && !rbit_reg;
  assign stamp = tamper_accept && timestamp_enable_reg;

  // Tamper flag next state; set wins over clear
  always_comb begin
    tamper_next = tamper_reg;
    case (tamper_reg)
      ARMED: begin
        if (tin_rise) tamper_next = LATCHED;
      end
      LATCHED: begin
        if (tamper_accept) tamper_next = LATCHED;
        else if (tamper_clear) tamper_next = ARMED;
      end
      default: tamper_next = ARMED;
    endcase
  end

  // Flag starts clear at power-up; battery retention is outside this block
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tamper_reg <= ARMED;
    else tamper_reg <= tamper_next;
  end

  // Control register bits other than the flag
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trim_mode_reg <= CTRL_RESET[TRIM_MODE_BIT];
      wbit_reg <= CTRL_RESET[WRITE_BIT];
      rbit_reg <= CTRL_RESET[READ_BIT];
    end else if (wr_ctrl) begin
      trim_mode_reg <= bus_req.wdata[TRIM_MODE_BIT];
      wbit_reg <= bus_req.wdata[WRITE_BIT];
      rbit_reg <= bus_req.wdata[READ_BIT];
    end
  end

  // Clearing the write bit loads the time registers into the core
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) core_load <= 1'b0;
    else core_load <= wr_ctrl && wbit_reg && !bus_req.wdata[WRITE_BIT];
  end

  assign freeze_updates = wbit_reg;

  // Timestamp enable is always writable and clear after power-up
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) timestamp_enable_reg <= 1'b0;
    else if (wr_trim) timestamp_enable_reg <= bus_req.wdata[TIMESTAMP_ENABLE_BIT];
  end

  // Trim code locks outside trim mode so a stray write cannot detune the clock
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) trim_code_reg <= TRIM_CODE_RESET;
    else if (wr_trim && trim_mode_reg) trim_code_reg <= bus_req.wdata[SIGN_BIT:0];
  end

  // Sign and magnitude become an add or remove request for the timekeeper
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) trim_adjust <= '0;
    else trim_adjust <= decode_trim(trim_code_reg);
  end

  // Time registers: timestamp or capture take priority over host writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      time_hold <= {TIME_BYTES{TIME_RESET}};
    end else if (stamp || capture) begin
      time_hold <= live_time;
    end else begin
      for (int i = 0; i < TIME_BYTES; i++) begin
        if (bus_req.wr && (bus_req.addr == ADDR_TIME0 + 4'(i))) time_hold[i] <= bus_req.wdata;
      end
    end
  end

  assign time_regs = time_hold;

  // Trim pin square wave; the correction itself never shows on it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trim_cnt_reg <= 32'h0;
      trim_out <= 1'b0;
    end else if (!trim_mode_reg) begin
      trim_cnt_reg <= 32'h0;
      trim_out <= 1'b0;
    end else if (trim_cnt_reg >= 32'(TRIM_HALF_CYCLES - 1)) begin
      trim_cnt_reg <= 32'h0;
      trim_out <= !trim_out;
    end else begin
      trim_cnt_reg <= trim_cnt_reg + 32'h1;
    end
  end

  // Read data; the flag reads zero while the supply is not valid
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else if (bus_req.rd) begin
      case (bus_req.addr)
        ADDR_CTRL: begin
          rd_data <= 8'h00;
          rd_data[TAMPER_BIT] <= (tamper_reg == LATCHED) && vdd_sync;
          rd_data[TRIM_MODE_BIT] <= trim_mode_reg;
          rd_data[WRITE_BIT] <= wbit_reg;
          rd_data[READ_BIT] <= rbit_reg;
        end
        ADDR_TRIM: begin
          rd_data <= 8'h00;
          rd_data[TIMESTAMP_ENABLE_BIT] <= timestamp_enable_reg;
          rd_data[SIGN_BIT:0] <= trim_code_reg;
        end
        ADDR_TIME0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, ADDR_TIME_LAST: begin
          rd_data <= time_hold[3'(bus_req.addr - ADDR_TIME0)];
        end
        default: rd_data <= 8'h00;
      endcase
    end else begin
      rd_data <= 8'h00;
    end
  end

  // Undervoltage supervisor
  supply_supervisor #(
    .FILTER_CYCLES(FILTER_CYCLES),
    .HOLD_CYCLES(HOLD_CYCLES)
  ) u_supervisor (
    .mclk(mclk),
    .rst_n(rst_n),
    .supply_above_trip(supply_above_trip),
    .sys_reset_o(sys_reset_o),
    .sys_reset_oe(sys_reset_oe)
  );

  // Checks on the flag, timestamp and trim logic
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  // Rules on the reset pin are checked inside the supervisor itself

  // Cycles since the trim pin last moved; kept apart from the divider so the check is independent
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trim_seen_reg <= 1'b0;
      trim_run_reg <= 32'h0;
    end else begin
      trim_seen_reg <= trim_out;
      if (!trim_mode_reg) trim_run_reg <= 32'h0;
      else if (trim_out != trim_seen_reg) trim_run_reg <= 32'h1;
      else trim_run_reg <= trim_run_reg + 32'h1;
    end
  end

  a_flag_sets: assert property (
    tin_rise && tamper_reg == ARMED |=> tamper_reg == LATCHED ##1 tamper_reg == LATCHED || $past(tamper_clear))
    else $error("tamper rise did not set flag");

  a_flag_ignores: assert property (
    tamper_reg == LATCHED && !tamper_clear && tin_rise |=>
      tamper_reg == LATCHED && ($stable(time_hold) || $past(capture || time_wr_any)))
    else $error("latched flag reacted to edge");

  a_flag_rearm: assert property (
    tamper_reg == LATCHED && tamper_clear && !tin_rise |=> tamper_reg == ARMED)
    else $error("detector did not re-arm");

  a_clear_supply: assert property (
    tamper_reg == LATCHED && wr_ctrl && !vdd_sync && !tamper_clear |=> tamper_reg == LATCHED)
    else $error("flag cleared without valid supply");

  a_read_supply: assert property (
    bus_req.rd && bus_req.addr == ADDR_CTRL |=> rd_data[TAMPER_BIT] == ($past(vdd_sync) && $past(tamper_reg == LATCHED)))
    else $error("flag read value wrong");

  a_stamp_copy: assert property (
    tamper_accept && timestamp_enable_reg |=> time_hold == $past(live_time))
    else $error("timestamp not taken");

  a_no_stamp: assert property (
    tin_rise && !timestamp_enable_reg && !capture && !time_wr_any |=> $stable(time_hold))
    else $error("time changed without timestamp enable");

  a_capture_live: assert property (
    wr_ctrl && bus_req.wdata[READ_BIT] && !rbit_reg |=> time_hold == $past(live_time) && rbit_reg)
    else $error("capture did not load live time");

  a_trim_locked: assert property (
    wr_trim && !trim_mode_reg |=> $stable(trim_code_reg))
    else $error("trim code written outside trim mode");

  a_trim_low: assert property (
    !trim_mode_reg ##1 !trim_mode_reg |-> !trim_out && trim_cnt_reg == 32'h0)
    else $error("trim pin not low");

  a_trim_decode: assert property (
    $stable(trim_code_reg) |=>
      trim_adjust.add == ($past(trim_code_reg[SIGN_BIT]) && $past(trim_code_reg[MAG_MSB:0]) != 5'h00)
      && trim_adjust.remove == (!$past(trim_code_reg[SIGN_BIT]) && $past(trim_code_reg[MAG_MSB:0]) != 5'h00)
      && trim_adjust.steps == $past(trim_code_reg[MAG_MSB:0]))
    else $error("trim correction decoded wrong");

  a_trim_zero: assert property (
    trim_code_reg == 6'h00 |=> !trim_adjust.add && !trim_adjust.remove)
    else $error("zero trim code applied a correction");

  a_trim_period: assert property (
    trim_mode_reg && $past(trim_mode_reg) && trim_out != trim_seen_reg |-> trim_run_reg == 32'(TRIM_HALF_CYCLES))
    else $error("trim pin half period wrong");

  a_timestamp_enable_write: assert property (
    wr_trim |=> timestamp_enable_reg == $past(bus_req.wdata[TIMESTAMP_ENABLE_BIT]))
    else $error("timestamp enable not written");

  a_time_still: assert property (
    !tamper_accept && !capture && !time_wr_any |=> $stable(time_hold))
    else $error("time registers moved without cause");

  c_stamp: cover property (stamp);
  c_capture_after_tamper: cover property (tamper_reg == LATCHED ##1 capture);
  c_clear_with_rise: cover property (tamper_reg == LATCHED && tamper_clear && tin_rise);
  c_trim_toggle: cover property (trim_mode_reg && $changed(trim_out));
endmodule // rtc_tamper_trim_reset
`default_nettype wire

// ===== rtl/rtc_pkg.sv
// Purpose: Shared constants and types for the tamper, trim and supervisor block
// Assumes: 250 MHz mclk; register indexes 0..8 on a plain port
// Notes: Time figures are in ns; cycle counts derive from the clock rate
package rtc_pkg;
  // Clock rate and derived period
  localparam int CLK_HZ = 250_000_000;
  localparam int CLK_NS = 1_000_000_000 / CLK_HZ;

  // Register indexes
  localparam logic [3:0] ADDR_CTRL = 4'h0;
  localparam logic [3:0] ADDR_TRIM = 4'h1;
  localparam logic [3:0] ADDR_TIME0 = 4'h2;
  localparam logic [3:0] ADDR_TIME_LAST = 4'h8;
  localparam int TIME_BYTES = 7;

  // Control register fields
  localparam int TAMPER_BIT = 7;
  localparam int TRIM_MODE_BIT = 2;
  localparam int WRITE_BIT = 1;
  localparam int READ_BIT = 0;

  // Trim register fields
  localparam int TIMESTAMP_ENABLE_BIT = 6;
  localparam int SIGN_BIT = 5;
  localparam int MAG_MSB = 4;

  // Values after reset
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [5:0] TRIM_CODE_RESET = 6'h00;
  localparam logic [7:0] TIME_RESET = 8'h00;

  // Trim output square wave
  localparam int TRIM_OUT_HZ = 512;
  localparam int TRIM_HALF_CYCLES = CLK_HZ / (2 * TRIM_OUT_HZ);

  // Supervisor timing; least times round up to whole cycles
  localparam int BROWNOUT_FILTER_NS = 10_000;
  localparam int POWER_UP_HOLD_NS = 100_000;
  localparam int FILTER_CYCLES = (BROWNOUT_FILTER_NS + CLK_NS - 1) / CLK_NS;
  localparam int HOLD_CYCLES = (POWER_UP_HOLD_NS + CLK_NS - 1) / CLK_NS;

  // Register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } regbus_req_type;

  // Correction handed to the timekeeper
  typedef struct packed {
    logic add;
    logic remove;
    logic [4:0] steps;
  } trim_adjust_type;

  typedef logic [TIME_BYTES-1:0][7:0] time_type;

  // Sign set adds pulses (slow clock), clear removes them; zero is no-op
  function automatic trim_adjust_type decode_trim(input logic [5:0] code);
    trim_adjust_type t;
    t.steps = code[MAG_MSB:0];
    t.add = code[SIGN_BIT] && (code[MAG_MSB:0] != 5'h00);
    t.remove = !code[SIGN_BIT] && (code[MAG_MSB:0] != 5'h00);
    return t;
  endfunction
endpackage

// ===== rtl/supply_supervisor.sv
// Purpose: Open-drain system reset from a filtered undervoltage
// Assumes: supply_above_trip is an asynchronous comparator pin
// Notes: Starts with reset asserted, as on power-up
`timescale 1ns/10ps
`default_nettype none
module supply_supervisor #(
  parameter int FILTER_CYCLES = rtc_pkg::FILTER_CYCLES,
  parameter int HOLD_CYCLES = rtc_pkg::HOLD_CYCLES
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Comparator pin
  input wire logic supply_above_trip,
  // Open-drain reset pin
  output logic sys_reset_o,
  output logic sys_reset_oe
);
  import rtc_pkg::*;

  typedef enum logic [3:0] {
    IN_RANGE = 4'b0001,
    FILTERING = 4'b0010,
    LOW = 4'b0100,
    HOLDING = 4'b1000
  } sup_state_type;

  sup_state_type state_reg;
  logic [31:0] cnt_reg;
  logic above_meta;
  logic above_sync;
  logic [31:0] below_run_reg;

  // Two-stage synchroniser on the comparator pin
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      above_meta <= 1'b0;
      above_sync <= 1'b0;
    end else begin
      above_meta <= supply_above_trip;
      above_sync <= above_meta;
    end
  end

  // Cycles the synchronised supply has stayed below trip; only the filter check reads it
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) below_run_reg <= 32'h0;
    else if (above_sync) below_run_reg <= 32'h0;
    else below_run_reg <= below_run_reg + 32'h1;
  end

  // Short dips are filtered so glitches never reset the system
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= LOW;
      cnt_reg <= 32'h0;
    end else begin
      case (state_reg)
        IN_RANGE: begin
          cnt_reg <= 32'h0;
          if (!above_sync) state_reg <= FILTERING;
        end
        FILTERING: begin
          if (above_sync) state_reg <= IN_RANGE;
          else if (cnt_reg >= 32'(FILTER_CYCLES - 1)) state_reg <= LOW;
          else cnt_reg <= cnt_reg + 32'h1;
        end
        LOW: begin
          cnt_reg <= 32'h0;
          if (above_sync) state_reg <= HOLDING;
        end
        HOLDING: begin
          if (!above_sync) begin
            state_reg <= LOW;
            cnt_reg <= 32'h0;
          end else if (cnt_reg >= 32'(HOLD_CYCLES - 1)) begin
            state_reg <= IN_RANGE;
          end else begin
            cnt_reg <= cnt_reg + 32'h1;
          end
        end
        default: state_reg <= LOW;
      endcase
    end
  end

  // Pin only ever pulls low; released means high impedance
  assign sys_reset_o = 1'b0;
  assign sys_reset_oe = (state_reg == LOW) || (state_reg == HOLDING);

  a_release_range: assert property (@(posedge mclk) disable iff (!rst_n)
    state_reg == IN_RANGE |-> !sys_reset_oe) else $error("reset driven while in range");
  a_filter_full: assert property (@(posedge mclk) disable iff (!rst_n)
    $rose(sys_reset_oe) |-> below_run_reg > 32'(FILTER_CYCLES)) else $error("early reset");
  a_hold_release: assert property (@(posedge mclk) disable iff (!rst_n)
    state_reg == HOLDING && cnt_reg < 32'(HOLD_CYCLES - 1) |=> sys_reset_oe) else $error("hold cut short");
  c_dip: cover property (@(posedge mclk) disable iff (!rst_n) $fell(sys_reset_oe));
endmodule // supply_supervisor
`default_nettype wire

// ===== dv/host_model.sv
// Purpose: Host processor model driving the register port
// Assumes: One request at a time; rd_data stands in the cycle after rd
// Notes: Strobes drop right after the taking edge, so calls never collide
`timescale 1ns/10ps
`default_nettype none
module host_model (
  // Clock
  input wire logic mclk,
  // Register port
  output var rtc_pkg::regbus_req_type bus_req,
  input wire logic [7:0] rd_data
);
  import rtc_pkg::*;

  // Idle port from time zero
  initial bus_req = '0;

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus_req.wr <= 1'b0;
  endtask

  // Read; data is taken at the edge closing the answer cycle
  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge mclk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus_req.rd <= 1'b0;
    @(posedge mclk);
    d = rd_data;
  endtask

  // A capture would overwrite the stamp, so look for it first
  task automatic fetch_stamp(output logic flag, output logic [7:0] b0);
    logic [7:0] c;
    rd(ADDR_CTRL, c);
    flag = c[TAMPER_BIT];
    b0 = 8'h00;
    if (flag) begin
      rd(ADDR_TIME0, b0);
    end
  endtask
endmodule  // host_model
`default_nettype wire

// ===== dv/rtc_tamper_trim_reset_bench.sv
// Purpose: Self-checking bench for tamper, trim and supervisor logic
// Assumes: Short counts so the supervisor and trim pin finish quickly
// Notes: Expected values come from the bit layout and the chosen counts
`timescale 1ns/10ps
`default_nettype none
module rtc_tamper_trim_reset_bench;
  import rtc_pkg::*;
  localparam int HALF = 8;
  localparam int FILT = 4;
  localparam int HOLD = 10;
  logic mclk = 1'b0;
  logic rst_n = 1'b0;
  regbus_req_type bus_req;
  logic [7:0] rd_data;
  logic tamper_input = 1'b0;
  logic main_supply_valid = 1'b1;
  logic supply_above_trip = 1'b1;
  logic trim_out, sys_reset_o, sys_reset_oe, freeze_updates, core_load;
  time_type live_time = '0;
  time_type time_regs;
  trim_adjust_type trim_adjust;
  trim_adjust_type ea;
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  logic f;
  logic [7:0] r;
  logic [5:0] codes [6] = '{6'h21, 6'h3f, 6'h01, 6'h1f, 6'h00, 6'h25};

  // 250 MHz clock
  always #2 mclk = ~mclk;

  rtc_tamper_trim_reset #(.TRIM_HALF_CYCLES(HALF), .FILTER_CYCLES(FILT), .HOLD_CYCLES(HOLD))
    rtc_tamper_trim_reset_i (.mclk(mclk), .rst_n(rst_n), .bus_req(bus_req), .rd_data(rd_data),
    .tamper_input(tamper_input), .main_supply_valid(main_supply_valid),
    .supply_above_trip(supply_above_trip), .trim_out(trim_out), .sys_reset_o(sys_reset_o),
    .sys_reset_oe(sys_reset_oe), .live_time(live_time), .time_regs(time_regs),
    .trim_adjust(trim_adjust), .freeze_updates(freeze_updates), .core_load(core_load));

  host_model host_model_i (.mclk(mclk), .bus_req(bus_req), .rd_data(rd_data));

  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // Comparisons by kind of result
  task automatic chk_bit(input string what, input logic e, input logic g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %b seen %b", what, e, g);
    end
  endtask
  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic chk_time(input string what, input time_type e, input time_type g);
    check_count++;
    if (g !== e) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge mclk);
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [7:0] e, input string what);
    logic [7:0] d;
    host_model_i.rd(a, d);
    chk_byte(what, e, d);
  endtask
  // Tamper level change, then room for the two-stage synchroniser
  task automatic pin(input logic v);
    tamper_input <= v;
    tick(6);
  endtask
  // Cycles until trim_out changes, 40 meaning it never did
  task automatic half(output int k);
    logic p;
    p = trim_out;
    k = 0;
    while (k < 40) begin
      tick(1);
      k++;
      if (trim_out !== p) break;
    end
  endtask

  // Cut a hang short; the whole run needs about 250 cycles
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end

  initial begin
    repeat (3) @(posedge mclk);
    chk_bit("oe in reset", 1'b1, sys_reset_oe);
    rst_n <= 1'b1;
    // Supervisor: power-up hold, glitch, brownout, recovery
    tick(HOLD - 1);
    chk_bit("oe power-up", 1'b1, sys_reset_oe);
    tick(8);
    chk_bit("oe released", 1'b0, sys_reset_oe);
    supply_above_trip <= 1'b0;
    tick(FILT - 1);
    supply_above_trip <= 1'b1;
    repeat (12) begin
      tick(1);
      chk_bit("oe glitch", 1'b0, sys_reset_oe);
    end
    supply_above_trip <= 1'b0;
    tick(FILT);
    chk_bit("oe early", 1'b0, sys_reset_oe);
    tick(6);
    chk_bit("oe brownout", 1'b1, sys_reset_oe);
    chk_bit("reset level", 1'b0, sys_reset_o);
    supply_above_trip <= 1'b1;
    tick(HOLD - 1);
    chk_bit("oe hold", 1'b1, sys_reset_oe);
    tick(8);
    chk_bit("oe end hold", 1'b0, sys_reset_oe);
    // Trim code: locked, then both signs at boundary magnitudes 1 and 31, and zero
    rdchk(ADDR_CTRL, 8'h00, "flag reset");
    host_model_i.wr(ADDR_TRIM, 8'h25);
    rdchk(ADDR_TRIM, 8'h00, "trim locked");
    host_model_i.wr(ADDR_CTRL, 8'h04);
    foreach (codes[i]) begin
      host_model_i.wr(ADDR_TRIM, {2'b00, codes[i]});
      rdchk(ADDR_TRIM, {2'b00, codes[i]}, "trim code");
      ea = '{codes[i][5] && |codes[i][4:0], !codes[i][5] && |codes[i][4:0], codes[i][4:0]};
      chk_byte("trim adjust", {1'b0, ea}, {1'b0, trim_adjust});
    end
    half(n);
    half(n);
    chk_byte("trim half", 8'(HALF), 8'(n));
    host_model_i.wr(ADDR_CTRL, 8'h00);
    host_model_i.wr(ADDR_TRIM, 8'h3f);
    rdchk(ADDR_TRIM, 8'h25, "trim kept");
    half(n);
    chk_byte("trim idle", 8'd40, 8'(n));
    chk_bit("trim pin off", 1'b0, trim_out);
    // Tamper without stamp, then supply gating of the flag
    live_time <= 56'h17161514131211;
    pin(1'b1);
    rdchk(ADDR_CTRL, 8'h80, "flag set");
    chk_time("no stamp", '0, time_regs);
    main_supply_valid <= 1'b0;
    tick(3);
    rdchk(ADDR_CTRL, 8'h00, "flag hidden");
    host_model_i.wr(ADDR_CTRL, 8'h00);
    main_supply_valid <= 1'b1;
    tick(3);
    rdchk(ADDR_CTRL, 8'h80, "flag kept");
    // Stamp enabled, re-arm, ignored second edge, capture afterwards
    pin(1'b0);
    host_model_i.wr(ADDR_TRIM, 8'h40);
    rdchk(ADDR_TRIM, 8'h65, "stamp enable");
    host_model_i.wr(ADDR_CTRL, 8'h00);
    rdchk(ADDR_CTRL, 8'h00, "flag cleared");
    live_time <= 56'h27262524232221;
    pin(1'b1);
    rdchk(ADDR_CTRL, 8'h80, "flag again");
    chk_time("stamp", 56'h27262524232221, time_regs);
    live_time <= 56'h37363534333231;
    pin(1'b0);
    pin(1'b1);
    chk_time("stamp kept", 56'h27262524232221, time_regs);
    host_model_i.fetch_stamp(f, r);
    chk_bit("stamp flag", 1'b1, f);
    chk_byte("stamp byte", 8'h21, r);
    host_model_i.wr(ADDR_CTRL, 8'h01);
    tick(1);
    chk_time("capture", 56'h37363534333231, time_regs);
    // Freeze level, host time write and an unmapped index
    host_model_i.wr(ADDR_CTRL, 8'h02);
    tick(1);
    chk_bit("freeze", 1'b1, freeze_updates);
    host_model_i.wr(ADDR_TIME0, 8'h5a);
    rdchk(ADDR_TIME0, 8'h5a, "time byte");
    rdchk(4'h9, 8'h00, "unmapped");
    host_model_i.wr(ADDR_CTRL, 8'h00);
    tick(1);
    chk_bit("core load", 1'b1, core_load);
    chk_bit("unfreeze", 1'b0, freeze_updates);
    tick(1);
    chk_bit("core load end", 1'b0, core_load);
    end_of_test();
  end
endmodule  // rtc_tamper_trim_reset_bench
`default_nettype wire
